// file: logic/power_fail_monitor_sequencer.v
// power-fail monitor sequencer: supply states, stop mode, registers
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "power_fail_regs.vh"
module power_fail_monitor_sequencer #(
   parameter XTAL_WARM_CYCLES = `XTAL_WARM_CYCLES,
   parameter PFW_QUAL_CYCLES = `PFW_QUAL_CYCLES
) (
   input wire clk,
   input wire rst,
   input wire ringOscIn,
   input wire poweronOk,
   input wire resetThreshOk,
   input wire warningThreshOk,
   input wire extReset_n,
   input wire wdtReset,
   input wire stopReq,
   input wire wakeIrq,
   input wire [3:0] addr,
   input wire [15:0] wdata,
   input wire wr,
   input wire rd,
   output reg [15:0] rdata,
   output reg monitorOn,
   output reg regulatorOn,
   output reg xtalOn,
   output reg sramRetain,
   output reg cpuReset,
   output reg stopActive,
   output reg [15:0] bootAddr,
   output reg irq
);
   // ****************************************
   // states
   // ****************************************
   localparam [8:0] S_OFF = 9'h001;
   localparam [8:0] S_WARM = 9'h002;
   localparam [8:0] S_RUN = 9'h004;
   localparam [8:0] S_HOLD = 9'h008;
   localparam [8:0] S_STOP = 9'h010;
   localparam [8:0] S_WAKE = 9'h020;
   localparam [8:0] S_POLL = 9'h040;
   localparam [8:0] S_DETECT = 9'h080;
   localparam [8:0] S_CONFIRM = 9'h100;

   // ****************************************
   // input synchronisers
   // ****************************************
   wire [3:0] asyncIn;
   reg [3:0] syncMeta;
   reg [3:0] syncOut;
   wire porOk;
   wire rstOk;
   wire warnOk;
   wire extRstReq;
   wire ringTick;

   // pin reset inverted first, so every stage idles low after reset
   assign asyncIn = {~extReset_n, warningThreshOk, resetThreshOk, poweronOk};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : gSync
         always @(posedge clk) begin
            if (rst) begin
               syncMeta[gi] <= 1'b0;
               syncOut[gi] <= 1'b0;
            end else begin
               syncMeta[gi] <= asyncIn[gi];
               syncOut[gi] <= syncMeta[gi];
            end
         end
      end
   endgenerate

   assign porOk = syncOut[0];
   assign rstOk = syncOut[1];
   assign warnOk = syncOut[2];
   assign extRstReq = syncOut[3];

   ring_tick_gen uTick (
      .clk(clk),
      .rst(rst),
      .ringOscIn(ringOscIn),
      .ringTick(ringTick)
   );

   // ****************************************
   // functions
   // ****************************************
   // polling interval in ring ticks; zero means continuous
   function [13:0] pollLimit;
      input [1:0] sel;
      begin
         case (sel)
            2'h1: pollLimit = `POLL_2E11;
            2'h2: pollLimit = `POLL_2E12;
            2'h3: pollLimit = `POLL_2E13;
            default: pollLimit = 14'h0000;
         endcase
      end
   endfunction

   function isMonitored;
      input [8:0] st;
      input stopOff;
      begin
         isMonitored = (st == S_RUN) || (st == S_WARM) || (st == S_HOLD)
            || (st == S_WAKE) || (st == S_DETECT) || (st == S_CONFIRM)
            || ((st == S_STOP) && !stopOff);
      end
   endfunction

   // ****************************************
   // registers
   // ****************************************
   reg stopMonitorOff;
   reg [1:0] pollSel;
   reg supplyWarnFlag;
   reg [2:0] intStatus;
   reg [2:0] intMask;
   reg pfBoot;

   reg [8:0] state;
   reg [8:0] next_state;
   reg [13:0] warmCnt;
   reg [13:0] pollCnt;
   reg [1:0] ringCnt;
   reg [2:0] relCnt;
   reg [13:0] qualCnt;
   reg stillGood;

   wire otherReset;
   wire warmDone;
   wire warnQualified;
   wire [2:0] events;
   wire monNow;
   wire warnNow;
   wire pfFail;
   wire stopExit;
   wire enterWarm;
   wire [13:0] pollEnd;

   assign otherReset = extRstReq | wdtReset;
   assign warmDone = (warmCnt == XTAL_WARM_CYCLES[13:0] - 14'h0001);
   assign monNow = isMonitored(state, stopMonitorOff);
   assign warnNow = monNow && rstOk && !warnOk;
   assign warnQualified = warnNow && (qualCnt == PFW_QUAL_CYCLES[13:0] - 14'h0001);
   assign pollEnd = pollLimit(pollSel);

   // ****************************************
   // next state
   // ****************************************
   always @* begin
      next_state = state;
      case (state)
         S_OFF: begin
            if (porOk)
               next_state = S_WARM;
         end
         S_WARM: begin
            if (warmDone && rstOk)
               next_state = S_RUN;
         end
         S_RUN: begin
            if (!rstOk)
               next_state = S_POLL;
            else if (otherReset)
               next_state = S_HOLD;
            else if (stopReq)
               next_state = S_STOP;
         end
         S_HOLD: begin
            if (!otherReset && relCnt == `OTHER_RELEASE_CYCLES - 3'h1)
               next_state = S_RUN;
         end
         S_STOP: begin
            if (!stopMonitorOff) begin
               if (!rstOk)
                  next_state = S_POLL;
               else if (warnQualified)
                  next_state = S_WAKE;
            end else if (wakeIrq) begin
               next_state = S_WAKE;
            end
         end
         S_WAKE: begin
            if (!rstOk)
               next_state = S_POLL;
            else if (warmDone)
               next_state = S_RUN;
         end
         S_POLL: begin
            if (pollEnd == 14'h0000 || (ringTick && pollCnt == pollEnd - 14'h0001))
               next_state = S_DETECT;
         end
         S_DETECT: begin
            if (ringTick && ringCnt == `DETECT_RING_CYCLES - 2'h1)
               next_state = (stillGood && rstOk) ? S_CONFIRM : S_POLL;
         end
         S_CONFIRM: begin
            if (!rstOk)
               next_state = S_POLL;
            else if (ringTick)
               next_state = S_WARM;
         end
         default: next_state = S_OFF;
      endcase
      if (!porOk)
         next_state = S_OFF;
   end

   assign pfFail = (next_state == S_POLL) && (state != S_POLL) && (state != S_DETECT)
      && (state != S_CONFIRM);
   assign stopExit = (state == S_WAKE) && (next_state == S_RUN);
   assign enterWarm = (next_state == S_WARM || next_state == S_WAKE) && (next_state != state);
   assign events = {stopExit, pfFail, warnQualified};

   // ****************************************
   // sequencer
   // ****************************************
   always @(posedge clk) begin
      if (rst) begin
         state <= S_OFF;
         warmCnt <= 14'h0000;
         pollCnt <= 14'h0000;
         ringCnt <= 2'h0;
         relCnt <= 3'h0;
         qualCnt <= 14'h0000;
         stillGood <= 1'b0;
         pfBoot <= 1'b0;
      end else begin
         state <= next_state;
         // warmup counter restarts on every entry to a warmup
         if (enterWarm || !(state == S_WARM || state == S_WAKE))
            warmCnt <= 14'h0000;
         else if (!warmDone)
            warmCnt <= warmCnt + 14'h0001;
         if (state != S_POLL)
            pollCnt <= 14'h0000;
         else if (ringTick)
            pollCnt <= pollCnt + 14'h0001;
         if (state != S_DETECT) begin
            ringCnt <= 2'h0;
            stillGood <= 1'b1;
         end else begin
            if (ringTick)
               ringCnt <= ringCnt + 2'h1;
            if (!rstOk)
               stillGood <= 1'b0;
         end
         if (state != S_HOLD || otherReset)
            relCnt <= 3'h0;
         else
            relCnt <= relCnt + 3'h1;
         // qualification needs an unbroken warning level
         if (!warnNow || warnQualified)
            qualCnt <= 14'h0000;
         else
            qualCnt <= qualCnt + 14'h0001;
         if (pfFail)
            pfBoot <= 1'b1;
         else if (next_state == S_HOLD || next_state == S_OFF)
            pfBoot <= 1'b0;
      end
   end

   // ****************************************
   // power and reset outputs
   // ****************************************
   always @(posedge clk) begin
      if (rst) begin
         monitorOn <= 1'b0;
         regulatorOn <= 1'b0;
         xtalOn <= 1'b0;
         sramRetain <= 1'b0;
         cpuReset <= 1'b1;
         stopActive <= 1'b0;
         bootAddr <= `APP_START_ADDR;
      end else begin
         monitorOn <= isMonitored(next_state, stopMonitorOff);
         regulatorOn <= (next_state == S_WARM) || (next_state == S_RUN)
            || (next_state == S_HOLD) || (next_state == S_WAKE);
         xtalOn <= (next_state == S_WARM) || (next_state == S_RUN)
            || (next_state == S_HOLD) || (next_state == S_WAKE);
         sramRetain <= (next_state == S_STOP) || (next_state == S_POLL)
            || (next_state == S_DETECT) || (next_state == S_CONFIRM);
         cpuReset <= (next_state != S_RUN) && (next_state != S_STOP)
            && (next_state != S_WAKE);
         stopActive <= (next_state == S_STOP) || (next_state == S_WAKE);
         if (pfFail)
            bootAddr <= `UTIL_ROM_ADDR;
         else if (next_state == S_OFF || next_state == S_HOLD)
            bootAddr <= `APP_START_ADDR;
      end
   end

   // ****************************************
   // register bus and interrupt
   // ****************************************
   // set wins over a read-clear in the same cycle
   always @(posedge clk) begin
      if (rst) begin
         // whole control word at once, so the constant keeps its width
         {pollSel, stopMonitorOff} <= `CTRL_RESET;
         intMask <= `MASK_RESET;
         intStatus <= 3'h0;
         supplyWarnFlag <= 1'b0;
         rdata <= 16'h0000;
         irq <= 1'b0;
      end else begin
         if (wr && addr == `ADDR_CTRL) begin
            stopMonitorOff <= wdata[`CTRL_STOP_MON_OFF];
            pollSel <= wdata[`CTRL_POLL_HI:`CTRL_POLL_LO];
         end
         if (wr && addr == `ADDR_INT_MASK)
            intMask <= wdata[2:0];
         if (warnQualified || (stopExit && warnNow))
            supplyWarnFlag <= 1'b1;
         else if (wr && addr == `ADDR_STATUS && wdata[`STAT_WARN_FLAG])
            supplyWarnFlag <= 1'b0;
         if (rd && addr == `ADDR_INT_STATUS)
            intStatus <= events;
         else
            intStatus <= intStatus | events;
         rdata <= 16'h0000;
         if (rd) begin
            case (addr)
               `ADDR_CTRL: rdata <= {13'h0000, pollSel, stopMonitorOff};
               `ADDR_STATUS: rdata <= {3'h0, state, 1'b0, stopActive, pfBoot,
                  supplyWarnFlag};
               `ADDR_INT_STATUS: rdata <= {13'h0000, intStatus};
               `ADDR_INT_MASK: rdata <= {13'h0000, intMask};
               default: rdata <= 16'h0000;
            endcase
         end
         // follows the status word as it will stand, so an event during a
         // read-clear keeps the line high
         irq <= |(((rd && addr == `ADDR_INT_STATUS) ? events : (intStatus | events))
            & intMask);
      end
   end
endmodule // power_fail_monitor_sequencer

// file: logic/power_fail_regs.vh
// constants of the power-fail monitor sequencer and its register map
`ifndef POWER_FAIL_REGS_VH
`define POWER_FAIL_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_INT_STATUS 4'h8
`define ADDR_INT_MASK 4'hc

// ****************************************
// field positions
// ****************************************
`define CTRL_STOP_MON_OFF 0
`define CTRL_POLL_LO 1
`define CTRL_POLL_HI 2
`define STAT_WARN_FLAG 0
`define STAT_PF_BOOT 1
`define STAT_STOP 2
`define STAT_STATE_LO 4
`define INT_WARN 0
`define INT_PF_RESET 1
`define INT_STOP_EXIT 2

// ****************************************
// reset values and boot addresses
// ****************************************
`define CTRL_RESET 3'h1
`define MASK_RESET 3'h0
`define UTIL_ROM_ADDR 16'h8000
`define APP_START_ADDR 16'h0000

// ****************************************
// timing
// ****************************************
`define CLK_HZ 10000000
`define XTAL_WARM_CYCLES 8192
`define PFW_QUAL_CYCLES 64
`define DETECT_RING_CYCLES 2'h2
`define OTHER_RELEASE_LIMIT 20
`define OTHER_RELEASE_CYCLES 3'h4
`define POLL_2E11 14'h0800
`define POLL_2E12 14'h1000
`define POLL_2E13 14'h2000

`endif

// file: logic/ring_tick_gen.v
// turns the free ring oscillator pin into one-cycle tick enables
`timescale 1ns/1ps
module ring_tick_gen (
   input wire clk,
   input wire rst,
   input wire ringOscIn,
   output reg ringTick
);
   // ****************************************
   // synchroniser and edge detect
   // ****************************************
   reg ringMeta;
   reg ringSync;
   reg ringLast;

   // first stage read only by the second
   always @(posedge clk) begin
      if (rst) begin
         ringMeta <= 1'b0;
         ringSync <= 1'b0;
         ringLast <= 1'b0;
         ringTick <= 1'b0;
      end else begin
         ringMeta <= ringOscIn;
         ringSync <= ringMeta;
         ringLast <= ringSync;
         ringTick <= ringSync & ~ringLast;
      end
   end
endmodule // ring_tick_gen

// file: tb/power_fail_monitor_sequencer_tb.sv
// self-checking bench of the power-fail monitor sequencer
`timescale 1ns/1ps
`include "power_fail_regs.vh"
module power_fail_monitor_sequencer_tb;
   logic clk, rst = 1'b1, wr = 1'b0, rd = 1'b0, stopReq = 1'b0, wakeIrq = 1'b0;
   logic wdtReset = 1'b0, extReset_n = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic [1:0] level = 2'h3;
   wire ringOscIn, poweronOk, resetThreshOk, warningThreshOk;
   wire monitorOn, regulatorOn, xtalOn, sramRetain, cpuReset, stopActive, irq;
   wire [15:0] rdata, bootAddr;
   int failCount = 0;
   int totalChecks = 0;
   int n;

   supply_model sup (.level(level), .poweronOk(poweronOk), .resetThreshOk(resetThreshOk),
      .warningThreshOk(warningThreshOk), .ringOscIn(ringOscIn));
   // short warmup and qualification keep the run brief
   power_fail_monitor_sequencer #(.XTAL_WARM_CYCLES(8), .PFW_QUAL_CYCLES(4)) dut (
      .clk(clk), .rst(rst), .ringOscIn(ringOscIn), .poweronOk(poweronOk),
      .resetThreshOk(resetThreshOk), .warningThreshOk(warningThreshOk),
      .extReset_n(extReset_n), .wdtReset(wdtReset), .stopReq(stopReq), .wakeIrq(wakeIrq),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .monitorOn(monitorOn),
      .regulatorOn(regulatorOn), .xtalOn(xtalOn), .sramRetain(sramRetain),
      .cpuReset(cpuReset), .stopActive(stopActive), .bootAddr(bootAddr), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ****************************************
   // tasks
   // ****************************************
   task chk(input logic [15:0] got, input logic [15:0] exp);
      totalChecks++;
      if (got !== exp) begin
         failCount++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // order: monitor, regulator, crystal, sram, cpu reset, stop
   task chkOut(input logic [5:0] care, input logic [5:0] exp);
      #1;
      chk({10'h000, care & {monitorOn, regulatorOn, xtalOn, sramRetain, cpuReset,
         stopActive}}, {10'h000, exp});
      // return on an edge, so the next stimulus lands there
      @(posedge clk);
   endtask
   task run(input int c);
      repeat (c) @(posedge clk);
   endtask
   task wrReg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rdReg(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   // bounded wait for the cpu to leave reset, n holds the cycles
   task waitRun(input int lim);
      n = 0;
      while (cpuReset !== 1'b0 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   task stopPulse;
      @(posedge clk);
      stopReq <= 1'b1;
      @(posedge clk);
      stopReq <= 1'b0;
      run(4);
   endtask
   task endTest(input string s);
      $display("test done: %s", s);
   endtask
   task tallyAndFinish;
      $display("checks %0d, mismatches %0d", totalChecks, failCount);
      if (failCount == 0 && totalChecks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      run(20);
      rst <= 1'b0;
      rdReg(`ADDR_CTRL, 16'h0001);
      rdReg(`ADDR_INT_MASK, 16'h0000);
      wrReg(4'h2, 16'hffff);
      rdReg(4'h2, 16'h0000);
      waitRun(200);
      chk(bootAddr, 16'h0000);
      chkOut(6'b111011, 6'b111000);
      endTest("power up");
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         if (s == 0) wdtReset <= 1'b1;
         else extReset_n <= 1'b0;
         run(8);
         chkOut(6'b111010, 6'b111010);
         wdtReset <= 1'b0;
         extReset_n <= 1'b1;
         waitRun(40);
         chk({15'h0000, n < 20}, 16'h0001);
      end
      endTest("other resets");
      level <= 2'h2;
      run(20);
      chk({15'h0000, irq}, 16'h0000);
      level <= 2'h3;
      wrReg(`ADDR_INT_MASK, 16'h0007);
      run(2);
      chk({15'h0000, irq}, 16'h0001);
      rdReg(`ADDR_STATUS, 16'h0041);
      rdReg(`ADDR_INT_STATUS, 16'h0001);
      rdReg(`ADDR_INT_STATUS, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      wrReg(`ADDR_STATUS, 16'h0001);
      rdReg(`ADDR_STATUS, 16'h0040);
      endTest("warning interrupt");
      level <= 2'h1;
      run(10);
      chkOut(6'b011010, 6'b000010);
      level <= 2'h3;
      waitRun(300);
      chk({15'h0000, n > 20}, 16'h0001);
      chk(bootAddr, 16'h8000);
      rdReg(`ADDR_INT_STATUS, 16'h0002);
      endTest("continuous poll");
      wrReg(`ADDR_CTRL, 16'h0002);
      level <= 2'h1;
      run(10);
      chkOut(6'b111010, 6'b000010);
      level <= 2'h3;
      waitRun(45000);
      chk({15'h0000, n > 40900 && n < 41200}, 16'h0001);
      rdReg(`ADDR_INT_STATUS, 16'h0002);
      endTest("periodic poll");
      wrReg(`ADDR_CTRL, 16'h0000);
      stopPulse();
      chkOut(6'b111111, 6'b100101);
      level <= 2'h2;
      run(60);
      chkOut(6'b011011, 6'b011000);
      rdReg(`ADDR_INT_STATUS, 16'h0005);
      level <= 2'h3;
      stopPulse();
      level <= 2'h1;
      run(10);
      chkOut(6'b011110, 6'b000110);
      level <= 2'h3;
      waitRun(300);
      endTest("stop monitored");
      wrReg(`ADDR_CTRL, 16'h0001);
      stopPulse();
      level <= 2'h1;
      run(10);
      chkOut(6'b100011, 6'b000001);
      wakeIrq <= 1'b1;
      run(3);
      wakeIrq <= 1'b0;
      run(10);
      chkOut(6'b011010, 6'b000010);
      level <= 2'h3;
      waitRun(300);
      endTest("stop unmonitored");
      level <= 2'h0;
      run(6);
      chkOut(6'b111010, 6'b000010);
      level <= 2'h3;
      waitRun(300);
      endTest("power-on loss");
      tallyAndFinish();
   end
   // hang guard, well beyond the long periodic poll
   initial begin
      #6000000;
      failCount++;
      tallyAndFinish();
   end
endmodule // power_fail_monitor_sequencer_tb

// file: tb/seq_port_monitor.sv
// port checker of the power-fail monitor sequencer
`timescale 1ns/1ps
module seq_port_monitor #(
   parameter XTAL_WARM_CYCLES = 8,
   parameter PFW_QUAL_CYCLES = 4
) (
   input wire clk,
   input wire rst,
   input wire ringOscIn,
   input wire poweronOk,
   input wire resetThreshOk,
   input wire warningThreshOk,
   input wire extReset_n,
   input wire wdtReset,
   input wire stopReq,
   input wire wakeIrq,
   input wire [3:0] addr,
   input wire [15:0] wdata,
   input wire wr,
   input wire rd,
   input wire [15:0] rdata,
   input wire monitorOn,
   input wire regulatorOn,
   input wire xtalOn,
   input wire sramRetain,
   input wire cpuReset,
   input wire stopActive,
   input wire [15:0] bootAddr,
   input wire irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ****************************************
   // assertions
   // ****************************************
   a_off_all_dark: assert property (
      !poweronOk [*4] |-> cpuReset && !monitorOn && !regulatorOn && !xtalOn)
      else $error("device not dark below power-on level");
   a_other_powered: assert property (
      !cpuReset ##1 wdtReset [*3] |-> cpuReset && monitorOn && regulatorOn && xtalOn)
      else $error("watchdog reset lost power");
   a_other_release: assert property (
      $fell(wdtReset) && resetThreshOk && cpuReset |-> ##[1:19] !cpuReset)
      else $error("slow release after watchdog reset");
   a_stop_dark: assert property (
      $rose(stopActive) && monitorOn |-> !regulatorOn && !xtalOn && sramRetain)
      else $error("stop entry left power on");
   a_fail_dark: assert property (
      (!cpuReset && monitorOn) ##1 (poweronOk && !resetThreshOk) [*4]
      |-> cpuReset && !regulatorOn && !xtalOn && sramRetain)
      else $error("supply fail not handled");
   a_wake_monitor: assert property (
      stopActive && !monitorOn && wakeIrq |-> ##[1:4] monitorOn)
      else $error("wake did not turn monitor on");
   a_warm_first: assert property (
      $rose(xtalOn) && cpuReset |-> cpuReset [*7])
      else $error("release before crystal warmup");
   a_rdata_quiet: assert property (
      !$past(rd) |-> rdata == 16'h0000)
      else $error("read data outside read slot");
   c_pf_boot: cover property ($fell(cpuReset) && bootAddr == 16'h8000);
   c_stop: cover property ($rose(stopActive));
   c_irq: cover property ($rose(irq));
endmodule // seq_port_monitor

bind power_fail_monitor_sequencer seq_port_monitor #(
   .XTAL_WARM_CYCLES(XTAL_WARM_CYCLES), .PFW_QUAL_CYCLES(PFW_QUAL_CYCLES)) mon (
   .clk(clk), .rst(rst), .ringOscIn(ringOscIn), .poweronOk(poweronOk),
   .resetThreshOk(resetThreshOk), .warningThreshOk(warningThreshOk),
   .extReset_n(extReset_n), .wdtReset(wdtReset), .stopReq(stopReq), .wakeIrq(wakeIrq),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .monitorOn(monitorOn),
   .regulatorOn(regulatorOn), .xtalOn(xtalOn), .sramRetain(sramRetain),
   .cpuReset(cpuReset), .stopActive(stopActive), .bootAddr(bootAddr), .irq(irq));

// file: tb/supply_model.sv
// model of the supply comparators and the free-running ring oscillator
`timescale 1ns/1ps
module supply_model (
   input wire logic [1:0] level,
   output wire poweronOk,
   output wire resetThreshOk,
   output wire warningThreshOk,
   output logic ringOscIn
);
   // ****************************************
   // comparators
   // ****************************************
   // level 0 below power-on, 1 below reset, 2 below warning, 3 good
   assign poweronOk = (level >= 2'h1);
   assign resetThreshOk = (level >= 2'h2);
   assign warningThreshOk = (level == 2'h3);
   // ****************************************
   // ring oscillator
   // ****************************************
   // runs free in every state, phase unrelated to clk, 20 clk period
   initial begin
      ringOscIn = 1'b0;
      #337;
      forever #1000 ringOscIn = ~ringOscIn;
   end
endmodule // supply_model
